/* design/lmp_pkg.sv */
// Shared constants and types of the LCD parallel host port
package lmp_pkg;

  // Bus geometry
  localparam int unsigned BUS_W         = 8;
  localparam int unsigned SER_CLK_BIT   = 6;
  localparam int unsigned SER_DATA_BIT  = 7;

  // Clock and phase times in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_SETUP_NS    = 20;
  localparam int unsigned T_STROBE_NS   = 80;
  localparam int unsigned T_HOLD_NS     = 20;
  localparam int unsigned T_RST_LOW_NS  = 1000;
  localparam int unsigned T_RST_REC_NS  = 1000;

  // Least times round up to whole cycles
  localparam int unsigned SETUP_CYC  =
    (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC =
    (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC   =
    (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_LOW_CYC =
    (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_REC_CYC =
    (T_RST_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 8;

  // Pin levels
  localparam logic STYLE_8080   = 1'b0;
  localparam logic STYLE_6800   = 1'b1;
  localparam logic SEL_PARALLEL = 1'b1;
  localparam logic DC_DATA      = 1'b1;
  localparam logic DC_CMD       = 1'b0;
  localparam logic RW_READ      = 1'b1;
  localparam logic RW_WRITE     = 1'b0;

  typedef enum logic {
    HOP_WRITE = 1'b0,
    HOP_READ  = 1'b1
  } lmp_op_t;

  // One transfer request from the user side
  typedef struct packed {
    lmp_op_t              op;
    logic                 data_cmd_sel;
    logic [BUS_W-1:0]     data;
  } lmp_cmd_t;

  // Every pin driven toward the LCD controller
  typedef struct packed {
    logic                 unit_select_n;
    logic                 unit_reset_n;
    logic                 data_cmd_sel;
    logic                 wr_pin;
    logic                 rd_pin;
    logic                 host_style_pin;
    logic                 par_ser_pin;
    logic [BUS_W-1:0]     host_bus_out;
    logic                 host_bus_oe_n;
  } lmp_pins_t;

  localparam logic [BUS_W-1:0] BUS_ZERO = 8'h00;

endpackage : lmp_pkg

/* design/lmp_sync.sv */
// Two-stage synchroniser for a bus sampled from pins
`timescale 1ns/1ps
module lmp_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_resetn,
  // Asynchronous input and its synchronised copy
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : lmp_sync

/* design/lmp_host.sv */
// Host controller driving the LCD parallel port pins
`timescale 1ns/1ps
// Operation
// - data_cmd_sel high marks display data, low marks an instruction.
// - In 8080 style host pulls write strobe low for every write.
// - In 8080 style host drives read strobe low to fetch data.
// - In 6800 style write pin is direction: high read, low write.
// - In 6800 style read pin is active-high enable framing each transfer.
// - host_bus is bidirectional; serial uses bit 6 clock, bit 7 data; this host always drives par_ser_pin to parallel.
module lmp_host #(
  parameter int unsigned SETUP_CYC   = lmp_pkg::SETUP_CYC,
  parameter int unsigned STROBE_CYC  = lmp_pkg::STROBE_CYC,
  parameter int unsigned HOLD_CYC    = lmp_pkg::HOLD_CYC,
  parameter int unsigned RST_LOW_CYC = lmp_pkg::RST_LOW_CYC,
  parameter int unsigned RST_REC_CYC = lmp_pkg::RST_REC_CYC
) (
  // Clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_resetn,
  // Configuration
  input  wire logic                        i_style_6800,
  // Request side
  input  wire logic                        i_req_valid,
  input  wire lmp_pkg::lmp_cmd_t           i_req_cmd,
  output logic                             o_req_ready,
  input  wire logic                        i_unit_reset_req,
  // Read answer
  output logic                             o_rd_valid,
  output logic [lmp_pkg::BUS_W-1:0]        o_rd_data,
  // Pins toward the LCD controller
  output lmp_pkg::lmp_pins_t               o_pins,
  input  wire logic [lmp_pkg::BUS_W-1:0]   i_host_bus_in
);

  localparam int unsigned CW = lmp_pkg::CNT_W;
  // Counter load used by the asynchronous reset branch
  localparam logic [CW-1:0] RST_LOW_LOAD = CW'(RST_LOW_CYC - 1);

  typedef enum logic [2:0] {
    ST_RST_LOW,
    ST_RST_REC,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } lmp_state_t;

  // Phase length minus one, the value loaded into the down counter
  function automatic logic [CW-1:0] phase_load(input int unsigned cyc);
    phase_load = CW'(cyc - 1);
  endfunction : phase_load

  // True while a transfer owns the pins
  function automatic logic in_cycle(input lmp_state_t st);
    in_cycle = (st == ST_SETUP) || (st == ST_STROBE) || (st == ST_HOLD);
  endfunction : in_cycle

  lmp_state_t                  state_q, state_d;
  logic [CW-1:0]               cnt_q, cnt_d;
  lmp_pkg::lmp_cmd_t           cmd_q, cmd_d;
  logic                        style_q, style_d;
  logic                        ready_q, ready_d;
  logic                        rd_valid_q, rd_valid_d;
  logic [lmp_pkg::BUS_W-1:0]   rd_data_q, rd_data_d;
  lmp_pkg::lmp_pins_t          pins_q, pins_d;
  logic [lmp_pkg::BUS_W-1:0]   bus_sync;
  logic                        active_d;
  logic                        is_read_d;

  // Pin bus is outside this clock domain
  lmp_sync #(
    .WIDTH (lmp_pkg::BUS_W)
  ) u_bus_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    (i_host_bus_in),
    .o_sync     (bus_sync)
  );

  // Sequencer
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    cmd_d      = cmd_q;
    style_d    = style_q;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    case (state_q)
      ST_RST_LOW: begin
        if (cnt_q == '0) begin
          state_d = ST_RST_REC;
          cnt_d   = phase_load(RST_REC_CYC);
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      ST_RST_REC: begin
        if (cnt_q == '0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      ST_IDLE: begin
        style_d = i_style_6800;
        if (i_unit_reset_req) begin
          state_d = ST_RST_LOW;
          cnt_d   = phase_load(RST_LOW_CYC);
        end else if (i_req_valid) begin
          state_d = ST_SETUP;
          cmd_d   = i_req_cmd;
          cnt_d   = phase_load(SETUP_CYC);
        end
      end
      ST_SETUP: begin
        if (cnt_q == '0) begin
          state_d = ST_STROBE;
          cnt_d   = phase_load(STROBE_CYC);
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      ST_STROBE: begin
        if (cnt_q == '0) begin
          state_d = ST_HOLD;
          cnt_d   = phase_load(HOLD_CYC);
          if (cmd_q.op == lmp_pkg::HOP_READ) begin
            // Sampled while the device still drives the bus
            rd_valid_d = 1'b1;
            rd_data_d  = bus_sync;
          end
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      ST_HOLD: begin
        if (cnt_q == '0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = '0;
      end
    endcase
    ready_d = (state_d == ST_IDLE) && !i_unit_reset_req;
  end

  // Pin levels follow the next state so pins leave flip-flops
  always_comb begin
    active_d  = in_cycle(state_d);
    is_read_d = (cmd_d.op == lmp_pkg::HOP_READ);
    pins_d    = pins_q;
    pins_d.unit_select_n  = !active_d;
    pins_d.unit_reset_n   = (state_d != ST_RST_LOW);
    pins_d.host_style_pin = style_d;
    pins_d.par_ser_pin    = lmp_pkg::SEL_PARALLEL;
    if (active_d) begin
      pins_d.data_cmd_sel = cmd_d.data_cmd_sel;
    end
    if (style_d == lmp_pkg::STYLE_6800) begin
      // Direction stands for the whole cycle, enable frames it
      pins_d.wr_pin = active_d ? (is_read_d ? lmp_pkg::RW_READ
                                            : lmp_pkg::RW_WRITE)
                               : lmp_pkg::RW_READ;
      pins_d.rd_pin = (state_d == ST_STROBE);
    end else begin
      pins_d.wr_pin = !((state_d == ST_STROBE) && !is_read_d);
      pins_d.rd_pin = !((state_d == ST_STROBE) && is_read_d);
    end
    // Write data stands from setup through hold
    pins_d.host_bus_oe_n = !(active_d && !is_read_d);
    pins_d.host_bus_out  = active_d ? cmd_d.data : lmp_pkg::BUS_ZERO;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q    <= ST_RST_LOW;
      cnt_q      <= RST_LOW_LOAD;
      cmd_q      <= '0;
      style_q    <= lmp_pkg::STYLE_8080;
      ready_q    <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= lmp_pkg::BUS_ZERO;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      cmd_q      <= cmd_d;
      style_q    <= style_d;
      ready_q    <= ready_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pins_q.unit_select_n  <= 1'b1;
      pins_q.unit_reset_n   <= 1'b0;
      pins_q.data_cmd_sel   <= lmp_pkg::DC_CMD;
      pins_q.wr_pin         <= 1'b1;
      pins_q.rd_pin         <= 1'b1;
      pins_q.host_style_pin <= lmp_pkg::STYLE_8080;
      pins_q.par_ser_pin    <= lmp_pkg::SEL_PARALLEL;
      pins_q.host_bus_out   <= lmp_pkg::BUS_ZERO;
      pins_q.host_bus_oe_n  <= 1'b1;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign o_req_ready = ready_q;
  assign o_rd_valid  = rd_valid_q;
  assign o_rd_data   = rd_data_q;
  assign o_pins      = pins_q;

endmodule : lmp_host

/* test/lmp_host_monitor.sv */
// Checker of the host port pin sequences
`timescale 1ns/1ps
module lmp_host_monitor (
  input wire logic               i_core_clk,
  input wire logic               i_resetn,
  input wire logic               i_req_valid,
  input wire lmp_pkg::lmp_cmd_t  i_req_cmd,
  input wire logic               o_req_ready,
  input wire logic               i_unit_reset_req,
  input wire logic               o_rd_valid,
  input wire lmp_pkg::lmp_pins_t o_pins
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_take;
    o_req_ready && i_req_valid && !i_unit_reset_req;
  endsequence
  sequence s_wr_low;
    o_pins.wr_pin[*2] ##1 !o_pins.wr_pin[*8] ##1 o_pins.wr_pin;
  endsequence
  sequence s_e_high;
    !o_pins.rd_pin[*2] ##1 o_pins.rd_pin[*8] ##1 !o_pins.rd_pin;
  endsequence
  property p_release;
    o_pins.unit_select_n |-> o_pins.host_bus_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("bus driven");
  property p_no_fight;
    !o_pins.unit_select_n && !o_pins.host_style_pin && !o_pins.rd_pin
      |-> o_pins.host_bus_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("read fight");
  property p_wr_8080;
    s_take ##0 (i_req_cmd.op == lmp_pkg::HOP_WRITE && !o_pins.host_style_pin)
      |=> s_wr_low;
  endproperty
  a_wr_8080: assert property (p_wr_8080) else $error("wr strobe");
  property p_e_6800;
    s_take ##0 o_pins.host_style_pin |=> s_e_high;
  endproperty
  a_e_6800: assert property (p_e_6800) else $error("enable pulse");
  property p_rd_valid;
    s_take ##0 i_req_cmd.op == lmp_pkg::HOP_READ
      |-> ##11 o_rd_valid ##1 !o_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("rd valid");
  property p_busy;
    s_take |=> (!o_req_ready)[*8] ##1 (!o_req_ready)[*4] ##1 o_req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready timing");
  property p_dc_hold;
    s_take |=> o_pins.data_cmd_sel == $past(i_req_cmd.data_cmd_sel)
      ##1 $stable(o_pins.data_cmd_sel)[*8];
  endproperty
  a_dc_hold: assert property (p_dc_hold) else $error("dc moved");
  property p_lcd_rst;
    o_req_ready && i_unit_reset_req
      |=> !o_pins.unit_reset_n[*4] ##1 o_pins.unit_reset_n;
  endproperty
  a_lcd_rst: assert property (p_lcd_rst) else $error("lcd reset");
endmodule : lmp_host_monitor
bind lmp_host lmp_host_monitor u_mon (.i_core_clk(i_core_clk),
  .i_resetn(i_resetn), .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
  .o_req_ready(o_req_ready), .i_unit_reset_req(i_unit_reset_req),
  .o_rd_valid(o_rd_valid), .o_pins(o_pins));

/* test/lmp_lcd_model.sv */
// Behavioural model of the LCD controller parallel port
`timescale 1ns/1ps
module lmp_lcd_model (
  input  wire lmp_pkg::lmp_pins_t i_pins,
  output logic [7:0]              o_dev_data,
  output logic                    o_dev_oe,
  output logic [7:0]              o_last_byte,
  output logic                    o_last_dc,
  output int                      o_wr_cnt
);
  wire sel  = !i_pins.unit_select_n && i_pins.par_ser_pin;
  wire m68  = i_pins.host_style_pin;
  initial o_wr_cnt = 0;
  assign o_dev_data = ~o_last_byte;
  assign o_dev_oe   = sel && (m68 ? (i_pins.rd_pin && i_pins.wr_pin)
                                  : !i_pins.rd_pin);
  always @(posedge i_pins.wr_pin or negedge i_pins.rd_pin
           or negedge i_pins.unit_reset_n) begin
    if (!i_pins.unit_reset_n) begin
      o_last_byte = 8'h00;
      o_last_dc   = 1'b0;
    end else if (sel && (m68 ? !i_pins.wr_pin : i_pins.rd_pin)) begin
      o_last_byte = i_pins.host_bus_out;
      o_last_dc   = i_pins.data_cmd_sel;
      o_wr_cnt++;
    end
  end
endmodule : lmp_lcd_model

/* test/lmp_host_tb.sv */
// Testbench of the LCD parallel host port
`timescale 1ns/1ps
module lmp_host_tb;
  logic clk = 0, rstn = 0, style = 0, vld = 0, lrst = 0, rdy, rdv, dev_oe, ldc;
  lmp_pkg::lmp_cmd_t  cmd = '0;
  lmp_pkg::lmp_pins_t pins;
  logic [7:0] rdd, bus, dev_d, lbyte, flt = 8'h5A;
  int wcnt, error_cnt = 0, checks = 0;
  always #5 clk = ~clk;
  assign bus = !pins.host_bus_oe_n ? pins.host_bus_out : dev_oe ? dev_d : flt;
  always @(posedge clk) flt <= ~bus;
  lmp_host #(.RST_LOW_CYC(4), .RST_REC_CYC(4)) dut (.i_core_clk(clk),
    .i_resetn(rstn), .i_style_6800(style), .i_req_valid(vld),
    .i_req_cmd(cmd), .o_req_ready(rdy), .i_unit_reset_req(lrst),
    .o_rd_valid(rdv), .o_rd_data(rdd), .o_pins(pins), .i_host_bus_in(bus));
  lmp_lcd_model lcd (.i_pins(pins), .o_dev_data(dev_d), .o_dev_oe(dev_oe),
    .o_last_byte(lbyte), .o_last_dc(ldc), .o_wr_cnt(wcnt));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task wait_ready;
    int n;
    n = 0;
    @(negedge clk);
    while (!rdy && n < 400) begin
      n++;
      @(negedge clk);
    end
    chk(rdy, 1'b1);
  endtask : wait_ready
  task send(input logic rd, input logic dc, input logic [7:0] d);
    wait_ready();
    @(posedge clk) #1 vld = 1;
    cmd = '{lmp_pkg::lmp_op_t'(rd), dc, d};
    @(posedge clk) #1 vld = 0;
  endtask : send
  task t_write(input logic st);
    @(posedge clk) #1 style = st;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pins.host_style_pin, st);
    for (int dc = 0; dc < 2; dc++) begin
      send(1'b0, dc[0], 8'hC3 ^ 8'(dc));
      wait_ready();
      chk(lbyte, 8'hC3 ^ 8'(dc));
      chk(ldc, dc[0]);
    end
    chk(pins.par_ser_pin, 1'b1);
  endtask : t_write
  task t_read(input logic [7:0] exp);
    int n;
    n = 0;
    send(1'b1, 1'b1, 8'h00);
    while (!rdv && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk(rdv, 1'b1);
    chk(rdd, exp);
    @(negedge clk) chk(rdv, 1'b0);
  endtask : t_read
  task t_refuse;
    int c;
    c = wcnt;
    send(1'b0, 1'b0, 8'h81);
    vld = 1;
    cmd.data = 8'h7E;
    repeat (5) @(posedge clk);
    #1 vld = 0;
    wait_ready();
    chk(16'(wcnt), 16'(c + 1));
    chk(lbyte, 8'h81);
  endtask : t_refuse
  task t_lcd_reset;
    wait_ready();
    @(posedge clk) #1 lrst = 1;
    @(posedge clk) #1 lrst = 0;
    chk(pins.unit_reset_n, 1'b0);
    wait_ready();
    chk(lbyte, 8'h00);
  endtask : t_lcd_reset
  initial begin
    repeat (4) @(posedge clk);
    chk({pins.unit_select_n, pins.unit_reset_n, pins.host_bus_oe_n}, 3'h5);
    #1 rstn = 1;
    t_write(1'b0);
    t_read(8'h3D);
    t_write(1'b1);
    t_read(8'h3D);
    t_refuse();
    t_lcd_reset();
    t_read(8'hFF);
    stop_test();
  end
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule : lmp_host_tb
